// [hdl/dcpwm_defines.svh]
// Purpose: Constants for the dual counter PWM/capture timer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef DCPWM_DEFINES_SVH
`define DCPWM_DEFINES_SVH

`define DCPWM_OFS_CNT1 8'h00
`define DCPWM_OFS_CNT2 8'h04
`define DCPWM_OFS_REGA 8'h08
`define DCPWM_OFS_REGB 8'h0c
`define DCPWM_OFS_PRSC 8'h10
`define DCPWM_OFS_CKSEL 8'h14
`define DCPWM_OFS_CTRL 8'h18
`define DCPWM_OFS_IRQEN 8'h1c
`define DCPWM_OFS_IRQCLR 8'h20

`define DCPWM_F_PRSC 4:0
`define DCPWM_F_C1SEL 2:0
`define DCPWM_F_C2SEL 5:3
`define DCPWM_F_CTRL 7:0
`define DCPWM_F_IRQEN 3:0
`define DCPWM_F_PEND 7:4
`define DCPWM_F_ALIGN 1:0
`define DCPWM_F_CNT 15:0

`define DCPWM_SEL_STOP 3'h0
`define DCPWM_SEL_PRSC 3'h1
`define DCPWM_SEL_EXT 3'h2
`define DCPWM_SEL_PACC 3'h3
`define DCPWM_SEL_SLOW 3'h4

`define DCPWM_PRESET 16'hffff
`define DCPWM_CNT_ONE 16'h0001
`define DCPWM_CNT_ZERO 16'h0000
`define DCPWM_PRSC_ONE 5'h01
`define DCPWM_PRSC_ZERO 5'h00
`define DCPWM_RST_CTRL 8'h00
`define DCPWM_RST_SEL 3'h0
`define DCPWM_RST_IRQ 4'h0
`define DCPWM_ZERO32 32'h00000000

`endif

// [hdl/dcpwm_pkg.sv]
// Purpose: Types for the dual counter PWM/capture timer
// Assumes: Nothing beyond the defines header
// Notes: Mode encoding follows enum order, 0 to 3
package dcpwm_pkg;

	typedef enum logic [1:0] {
		DCPWM_MODE_PWM,
		DCPWM_MODE_DUAL_CAPTURE,
		DCPWM_MODE_DUAL_TIMER,
		DCPWM_MODE_SINGLE_CAPTURE
	} dcpwm_mode_t;

	// Control register, bit 7 down to bit 0
	typedef struct packed {
		logic pulse_acc_low;
		logic pin_b_rising;
		logic pin_a_rising;
		logic pin_a_initial_level;
		logic pin_b_preset_enable;
		logic pin_a_output_enable;
		logic [1:0] mode;
	} dcpwm_ctrl_t;

	// One bit per interrupt source, d in bit 3 down to a in bit 0
	typedef struct packed {
		logic d;
		logic c;
		logic b;
		logic a;
	} dcpwm_irq_t;

endpackage

// [hdl/dcpwm_top.sv]
// Purpose: Dual 16-bit down-counter timer with reload/capture and two pins
// Assumes: Pins and slow clock synchronous to pclk; APB register access
// Notes: Interrupt lines are level outputs, one cycle behind pending
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dcpwm_defines.svh"

module dcpwm_top import dcpwm_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_a_in,
	input wire logic pin_b_in,
	input wire logic slow_clock,
	output logic pin_a_out,
	output logic pin_a_oe,
	output logic irq_timer_one,
	output logic irq_timer_two
);

	// Configuration state
	logic [4:0] prescale;
	logic [2:0] counter_one_clock_select;
	logic [2:0] counter_two_clock_select;
	dcpwm_ctrl_t ctrl;
	dcpwm_irq_t irq_enable;
	logic [4:0] next_prescale;
	logic [2:0] next_c1sel;
	logic [2:0] next_c2sel;
	dcpwm_ctrl_t next_ctrl;
	dcpwm_irq_t next_irq_enable;

	// Timer state
	logic [15:0] counter_one;
	logic [15:0] counter_two;
	logic [15:0] reload_capture_reg_a;
	logic [15:0] reload_capture_reg_b;
	logic [4:0] prsc_cnt;
	logic reload_from_b;
	dcpwm_irq_t pending;
	logic pin_a_level;
	logic pin_a_prev;
	logic pin_b_prev;
	logic slow_prev;
	logic irq_one;
	logic irq_two;
	logic oe_q;
	logic [15:0] next_counter_one;
	logic [15:0] next_counter_two;
	logic [15:0] next_reg_a;
	logic [15:0] next_reg_b;
	logic [4:0] next_prsc_cnt;
	logic next_reload_from_b;
	dcpwm_irq_t next_pending;
	dcpwm_irq_t pend_set;
	logic next_pin_a_level;
	logic next_irq_one;
	logic next_irq_two;
	logic next_oe;

	// Bus state
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	dcpwm_mode_t mode;
	logic capture_mode;
	logic timer_mode;
	logic presc_tick;
	logic slow_tick;
	logic pin_a_edge;
	logic pin_b_edge;
	logic pin_b_event;
	logic pin_b_gate;
	logic wr;
	logic [1:0] tick;
	logic [2:0] sel [2];
	dcpwm_irq_t clear;

	assign mode = dcpwm_mode_t'(ctrl.mode);
	assign capture_mode = (mode == DCPWM_MODE_DUAL_CAPTURE) ||
		(mode == DCPWM_MODE_SINGLE_CAPTURE);
	assign timer_mode = (mode == DCPWM_MODE_DUAL_TIMER) ||
		(mode == DCPWM_MODE_SINGLE_CAPTURE);
	assign wr = psel & penable & pready & pwrite;
	assign presc_tick = (prsc_cnt == `DCPWM_PRSC_ZERO);
	assign slow_tick = slow_clock & ~slow_prev;
	// Edge sense per capture input
	assign pin_a_edge = ctrl.pin_a_rising ? (pin_a_in & ~pin_a_prev) :
		(~pin_a_in & pin_a_prev);
	assign pin_b_edge = ctrl.pin_b_rising ? (pin_b_in & ~pin_b_prev) :
		(~pin_b_in & pin_b_prev);
	assign pin_b_event = pin_b_edge;
	assign pin_b_gate = pin_b_in ^ ctrl.pulse_acc_low;
	assign sel[0] = counter_one_clock_select;
	assign sel[1] = counter_two_clock_select;

	// Count enable per counter from its selector
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tick
			always_comb begin
				case (sel[gi])
				`DCPWM_SEL_PRSC: tick[gi] = presc_tick;
				`DCPWM_SEL_EXT: tick[gi] = pin_b_event & ~capture_mode;
				`DCPWM_SEL_PACC: tick[gi] = presc_tick & pin_b_gate &
					~capture_mode;
				`DCPWM_SEL_SLOW: tick[gi] = slow_tick;
				default: tick[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Configuration registers
	always_comb begin
		next_prescale = prescale;
		next_c1sel = counter_one_clock_select;
		next_c2sel = counter_two_clock_select;
		next_ctrl = ctrl;
		next_irq_enable = irq_enable;
		if (wr) begin
			case (paddr)
			`DCPWM_OFS_PRSC: next_prescale = pwdata[`DCPWM_F_PRSC];
			`DCPWM_OFS_CKSEL: begin
				next_c1sel = pwdata[`DCPWM_F_C1SEL];
				next_c2sel = pwdata[`DCPWM_F_C2SEL];
			end
			`DCPWM_OFS_CTRL: next_ctrl = dcpwm_ctrl_t'(pwdata[`DCPWM_F_CTRL]);
			`DCPWM_OFS_IRQEN: next_irq_enable =
				dcpwm_irq_t'(pwdata[`DCPWM_F_IRQEN]);
			default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= `DCPWM_PRSC_ZERO;
			counter_one_clock_select <= `DCPWM_RST_SEL;
			counter_two_clock_select <= `DCPWM_RST_SEL;
			ctrl <= `DCPWM_RST_CTRL;
			irq_enable <= `DCPWM_RST_IRQ;
		end else begin
			prescale <= next_prescale;
			counter_one_clock_select <= next_c1sel;
			counter_two_clock_select <= next_c2sel;
			ctrl <= next_ctrl;
			irq_enable <= next_irq_enable;
		end
	end

	// Counters, capture, pin A and pending bits
	always_comb begin
		next_counter_one = counter_one;
		next_counter_two = counter_two;
		next_reg_a = reload_capture_reg_a;
		next_reg_b = reload_capture_reg_b;
		next_reload_from_b = reload_from_b;
		next_pin_a_level = pin_a_level;
		pend_set = `DCPWM_RST_IRQ;
		clear = `DCPWM_RST_IRQ;
		next_prsc_cnt = presc_tick ? prescale :
			prsc_cnt - `DCPWM_PRSC_ONE;

		// Counter one
		case (mode)
		DCPWM_MODE_PWM: begin
			if (tick[0]) begin
				if (counter_one == `DCPWM_CNT_ZERO) begin
					next_counter_one = reload_from_b ?
						reload_capture_reg_b : reload_capture_reg_a;
					next_reload_from_b = ~reload_from_b;
					pend_set.a = ~reload_from_b;
					pend_set.b = reload_from_b;
					if (ctrl.pin_a_output_enable)
						next_pin_a_level = ~pin_a_level;
				end else begin
					next_counter_one = counter_one - `DCPWM_CNT_ONE;
				end
			end
		end
		DCPWM_MODE_DUAL_CAPTURE: begin
			if (tick[0]) begin
				next_counter_one = counter_one - `DCPWM_CNT_ONE;
				pend_set.c = (counter_one == `DCPWM_CNT_ZERO);
			end
			// Capture takes the value before any preset
			if (pin_a_edge) begin
				next_reg_a = counter_one;
				pend_set.a = 1'b1;
				if (ctrl.pin_a_output_enable)
					next_counter_one = `DCPWM_PRESET;
			end
			if (pin_b_edge) begin
				next_reg_b = counter_one;
				pend_set.b = 1'b1;
				if (ctrl.pin_b_preset_enable)
					next_counter_one = `DCPWM_PRESET;
			end
		end
		default: begin
			if (tick[0]) begin
				if (counter_one == `DCPWM_CNT_ZERO) begin
					next_counter_one = reload_capture_reg_a;
					if (ctrl.pin_a_output_enable) begin
						next_pin_a_level = ~pin_a_level;
						pend_set.c = ~pin_a_level;
					end
				end else begin
					next_counter_one = counter_one - `DCPWM_CNT_ONE;
				end
			end
		end
		endcase
		// Alternation restarts at A whenever counter one's select is STOP or the mode is not PWM
		if (mode != DCPWM_MODE_PWM ||
			counter_one_clock_select == `DCPWM_SEL_STOP)
			next_reload_from_b = 1'b0;
		// Toggle output parks at the programmed level while idle
		if (counter_one_clock_select == `DCPWM_SEL_STOP ||
			!ctrl.pin_a_output_enable || mode == DCPWM_MODE_DUAL_CAPTURE)
			next_pin_a_level = ctrl.pin_a_initial_level;

		// Counter two
		if (tick[1]) begin
			if (counter_two == `DCPWM_CNT_ZERO) begin
				pend_set.d = 1'b1;
				if (mode == DCPWM_MODE_DUAL_TIMER)
					next_counter_two = reload_capture_reg_b;
				else
					next_counter_two = counter_two - `DCPWM_CNT_ONE;
			end else begin
				next_counter_two = counter_two - `DCPWM_CNT_ONE;
			end
		end
		if (mode == DCPWM_MODE_SINGLE_CAPTURE && pin_b_edge) begin
			next_reg_b = counter_two;
			pend_set.b = 1'b1;
			if (ctrl.pin_b_preset_enable)
				next_counter_two = `DCPWM_PRESET;
		end

		// Software writes to the data registers take priority
		if (wr) begin
			case (paddr)
			`DCPWM_OFS_CNT1: next_counter_one = pwdata[`DCPWM_F_CNT];
			`DCPWM_OFS_CNT2: next_counter_two = pwdata[`DCPWM_F_CNT];
			`DCPWM_OFS_REGA: next_reg_a = pwdata[`DCPWM_F_CNT];
			`DCPWM_OFS_REGB: next_reg_b = pwdata[`DCPWM_F_CNT];
			`DCPWM_OFS_IRQCLR: clear = dcpwm_irq_t'(pwdata[`DCPWM_F_IRQEN]);
			default: ;
			endcase
		end
		// A set in the clearing cycle survives
		next_pending = (pending & ~clear) | pend_set;
		next_irq_one = (pending.a & irq_enable.a) |
			(pending.b & irq_enable.b) |
			(pending.c & (timer_mode ? irq_enable.a : irq_enable.c));
		next_irq_two = pending.d & irq_enable.d;
		next_oe = ctrl.pin_a_output_enable &&
			mode != DCPWM_MODE_DUAL_CAPTURE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_one <= `DCPWM_CNT_ZERO;
			counter_two <= `DCPWM_CNT_ZERO;
			reload_capture_reg_a <= `DCPWM_CNT_ZERO;
			reload_capture_reg_b <= `DCPWM_CNT_ZERO;
			prsc_cnt <= `DCPWM_PRSC_ZERO;
			reload_from_b <= 1'b0;
			pending <= `DCPWM_RST_IRQ;
			pin_a_level <= 1'b0;
			pin_a_prev <= 1'b0;
			pin_b_prev <= 1'b0;
			slow_prev <= 1'b0;
			irq_one <= 1'b0;
			irq_two <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			counter_one <= next_counter_one;
			counter_two <= next_counter_two;
			reload_capture_reg_a <= next_reg_a;
			reload_capture_reg_b <= next_reg_b;
			prsc_cnt <= next_prsc_cnt;
			reload_from_b <= next_reload_from_b;
			pending <= next_pending;
			pin_a_level <= next_pin_a_level;
			pin_a_prev <= pin_a_in;
			pin_b_prev <= pin_b_in;
			slow_prev <= slow_clock;
			irq_one <= next_irq_one;
			irq_two <= next_irq_two;
			oe_q <= next_oe;
		end
	end

	assign pin_a_out = pin_a_level;
	assign pin_a_oe = oe_q;
	assign irq_timer_one = irq_one;
	assign irq_timer_two = irq_two;

	// APB answer: data and status prepared during setup, zero wait
	always_comb begin
		next_prdata = `DCPWM_ZERO32;
		next_pslverr = 1'b0;
		next_pready = psel & ~penable;
		if (psel & ~penable & ~pwrite) begin
			case (paddr)
			`DCPWM_OFS_CNT1: next_prdata[`DCPWM_F_CNT] = counter_one;
			`DCPWM_OFS_CNT2: next_prdata[`DCPWM_F_CNT] = counter_two;
			`DCPWM_OFS_REGA:
				next_prdata[`DCPWM_F_CNT] = reload_capture_reg_a;
			`DCPWM_OFS_REGB:
				next_prdata[`DCPWM_F_CNT] = reload_capture_reg_b;
			`DCPWM_OFS_PRSC: next_prdata[`DCPWM_F_PRSC] = prescale;
			`DCPWM_OFS_CKSEL: begin
				next_prdata[`DCPWM_F_C1SEL] = counter_one_clock_select;
				next_prdata[`DCPWM_F_C2SEL] = counter_two_clock_select;
			end
			`DCPWM_OFS_CTRL: next_prdata[`DCPWM_F_CTRL] = ctrl;
			`DCPWM_OFS_IRQEN: begin
				next_prdata[`DCPWM_F_IRQEN] = irq_enable;
				next_prdata[`DCPWM_F_PEND] = pending;
			end
			`DCPWM_OFS_IRQCLR: ;
			default: next_pslverr = 1'b1;
			endcase
		end else if (psel & ~penable) begin
			case (paddr)
			`DCPWM_OFS_CNT1, `DCPWM_OFS_CNT2, `DCPWM_OFS_REGA,
			`DCPWM_OFS_REGB, `DCPWM_OFS_PRSC, `DCPWM_OFS_CKSEL,
			`DCPWM_OFS_CTRL, `DCPWM_OFS_IRQEN,
			`DCPWM_OFS_IRQCLR: next_pslverr = 1'b0;
			default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `DCPWM_ZERO32;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

endmodule

// [verification/dcpwm_checker_assertions.sv]
// Purpose: Port checks for the dual counter timer
// Assumes: Control, select and enables shadowed from APB writes
// Notes: Registered outputs are judged once the shadow has settled
`timescale 1ns/1ps
`include "dcpwm_defines.svh"
module dcpwm_checker import dcpwm_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pin_a_in,
	input wire logic pin_b_in,
	input wire logic slow_clock,
	input wire logic pin_a_out,
	input wire logic pin_a_oe,
	input wire logic irq_timer_one,
	input wire logic irq_timer_two
);
	dcpwm_ctrl_t ctl;
	dcpwm_irq_t ien;
	logic [5:0] sel;
	logic wr_ok;
	assign wr_ok = psel && penable && pready && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= '0;
			ien <= '0;
			sel <= '0;
		end else if (wr_ok) begin
			if (paddr == `DCPWM_OFS_CTRL)
				ctl <= pwdata[`DCPWM_F_CTRL];
			if (paddr == `DCPWM_OFS_IRQEN)
				ien <= pwdata[`DCPWM_F_IRQEN];
			if (paddr == `DCPWM_OFS_CKSEL)
				sel <= pwdata[5:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_oe_by_mode: assert property (
		$stable(ctl) |-> pin_a_oe == (ctl.pin_a_output_enable &&
		ctl.mode != 2'h1)) else $error("pin A enable wrong");
	a_capture_no_drive: assert property (
		(ctl.mode == 2'h1) [*2] |-> !pin_a_oe)
		else $error("pin A driven in capture");
	a_park_level: assert property (
		$stable(sel) && $stable(ctl) && (sel[2:0] == 3'h0 ||
		!ctl.pin_a_output_enable) |->
		pin_a_out == ctl.pin_a_initial_level)
		else $error("pin A not at initial level");
	a_irq1_masked: assert property (
		(ien[2:0] == 3'h0) [*2] |-> !irq_timer_one)
		else $error("irq one while masked");
	a_irq2_masked: assert property (
		!ien.d ##1 !ien.d |-> !irq_timer_two)
		else $error("irq two while masked");
	a_ready_after_setup: assert property (
		psel && !penable |=> pready) else $error("no ready");
	a_ready_pulse: assert property (
		pready |=> !pready) else $error("ready too long");
	a_rdata_idle: assert property (
		!pready |-> prdata == 32'h0) else $error("read data idle");
	a_err_unmapped: assert property (
		pready |-> pslverr == (paddr > `DCPWM_OFS_IRQCLR ||
		paddr[1:0] != 2'h0)) else $error("slave error wrong");
	c_irq_two: cover property ($rose(irq_timer_two));
	c_toggle: cover property ($changed(pin_a_out) && pin_a_oe);
	c_err: cover property (pready && pslverr);
endmodule
bind dcpwm_top dcpwm_checker dcpwm_checker_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .pin_a_in, .pin_b_in, .slow_clock, .pin_a_out,
	.pin_a_oe, .irq_timer_one, .irq_timer_two);

// [verification/dcpwm_pins.sv]
// Purpose: Outside sources for the timer pins and slow clock
// Assumes: Levels change only just after pclk edges
// Notes: Slow clock stands low between bursts
`timescale 1ns/1ps
module dcpwm_pins (
	input wire logic pclk,
	output logic src_a,
	output logic src_b,
	output logic slow_clock
);
	initial begin
		src_a = 1'b0;
		src_b = 1'b0;
		slow_clock = 1'b0;
	end
	task automatic drive(input logic pin, input logic v);
		@(posedge pclk);
		if (pin)
			src_b <= v;
		else
			src_a <= v;
		repeat (2) @(posedge pclk);
	endtask
	// A fifth of pclk rate: two cycles high, then three low
	task automatic slow(input int k);
		repeat (k) begin
			@(posedge pclk);
			slow_clock <= 1'b1;
			repeat (2) @(posedge pclk);
			slow_clock <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask
endmodule

// [verification/dcpwm_tb_top.sv]
// Purpose: Directed bench for the dual counter timer
// Assumes: Registers reached over APB
// Notes: Counters held still during captures so values are exact
`timescale 1ns/1ps
`include "dcpwm_defines.svh"
module dcpwm_tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, pin_a_out, pin_a_oe, e;
	logic irq_timer_one, irq_timer_two;
	logic src_a, src_b, slow_clock, pin_a_in;
	int mismatches = 0;
	int checked = 0;
	int n;
	always #20 pclk = ~pclk;
	assign pin_a_in = pin_a_oe ? pin_a_out : src_a;
	dcpwm_top dcpwm_top_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pin_a_in, .pin_b_in(src_b), .slow_clock, .pin_a_out,
		.pin_a_oe, .irq_timer_one, .irq_timer_two);
	dcpwm_pins dcpwm_pins_inst (.pclk, .src_a, .src_b, .slow_clock);
	task automatic results();
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] g);
		checked++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), x, r);
	endtask
	task automatic wchg();
		logic v;
		v = pin_a_out;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pin_a_out === v && n < 100);
	endtask
	task automatic t_pwm();
		wr(`DCPWM_OFS_REGA, 32'h2);
		wr(`DCPWM_OFS_REGB, 32'h5);
		wr(`DCPWM_OFS_CTRL, 32'h04);
		wr(`DCPWM_OFS_IRQEN, 32'h0b);
		wr(`DCPWM_OFS_CKSEL, 32'h09);
		wchg();
		wchg();
		chk("high width", 3, n);
		wchg();
		chk("low width", 6, n);
		rdc(`DCPWM_OFS_IRQEN, 32'hbb);
		chk("irq one", 1, irq_timer_one);
		chk("irq two", 1, irq_timer_two);
		wr(`DCPWM_OFS_CKSEL, 32'h0);
		wr(`DCPWM_OFS_IRQCLR, 32'hf);
		rdc(`DCPWM_OFS_IRQEN, 32'h0b);
		wr(`DCPWM_OFS_CKSEL, 32'h01);
		wchg();
		wchg();
		chk("restart width", 3, n);
		wr(`DCPWM_OFS_CKSEL, 32'h0);
	endtask
	task automatic t_dual_cap();
		wr(`DCPWM_OFS_IRQCLR, 32'hf);
		wr(`DCPWM_OFS_CTRL, 32'h25);
		wr(`DCPWM_OFS_CNT1, 32'h1234);
		dcpwm_pins_inst.drive(1, 1);
		rdc(`DCPWM_OFS_REGB, 32'h5);
		dcpwm_pins_inst.drive(0, 1);
		dcpwm_pins_inst.drive(1, 0);
		rdc(`DCPWM_OFS_REGA, 32'h1234);
		rdc(`DCPWM_OFS_REGB, 32'hffff);
		rdc(`DCPWM_OFS_CNT1, 32'hffff);
		rdc(`DCPWM_OFS_IRQEN, 32'h3b);
		dcpwm_pins_inst.drive(0, 0);
		wr(`DCPWM_OFS_CNT1, 32'h10);
		wr(`DCPWM_OFS_CKSEL, 32'h02);
		dcpwm_pins_inst.drive(1, 1);
		dcpwm_pins_inst.drive(1, 0);
		rdc(`DCPWM_OFS_CNT1, 32'h10);
		rdc(`DCPWM_OFS_REGB, 32'h10);
		wr(`DCPWM_OFS_CNT1, 32'h0);
		wr(`DCPWM_OFS_CKSEL, 32'h01);
		rdc(`DCPWM_OFS_IRQEN, 32'h7b);
		wr(`DCPWM_OFS_CKSEL, 32'h0);
	endtask
	task automatic t_single();
		wr(`DCPWM_OFS_IRQCLR, 32'hf);
		wr(`DCPWM_OFS_CTRL, 32'h4b);
		wr(`DCPWM_OFS_CNT2, 32'habc);
		wr(`DCPWM_OFS_CKSEL, 32'h20);
		dcpwm_pins_inst.drive(1, 1);
		dcpwm_pins_inst.slow(3);
		rdc(`DCPWM_OFS_REGB, 32'habc);
		rdc(`DCPWM_OFS_CNT2, 32'hfffc);
		rdc(`DCPWM_OFS_IRQEN, 32'h2b);
		dcpwm_pins_inst.drive(1, 0);
	endtask
	task automatic t_timer();
		wr(`DCPWM_OFS_IRQCLR, 32'hf);
		wr(`DCPWM_OFS_CTRL, 32'h56);
		wr(`DCPWM_OFS_REGA, 32'h3);
		wr(`DCPWM_OFS_REGB, 32'h1);
		wr(`DCPWM_OFS_CNT1, 32'h0);
		wr(`DCPWM_OFS_CNT2, 32'h0);
		chk("start level", 1, pin_a_out);
		wr(`DCPWM_OFS_CKSEL, 32'h11);
		wchg();
		wchg();
		chk("low width", 4, n);
		wchg();
		chk("high width", 4, n);
		dcpwm_pins_inst.drive(1, 1);
		rdc(`DCPWM_OFS_CNT2, 32'h1);
		apb(1'b0, `DCPWM_OFS_IRQEN, 32'h0);
		chk("pending c d", 2'h3, r[7:6]);
		chk("irq two", 1, irq_timer_two);
		chk("irq one c", 1, irq_timer_one);
		wr(`DCPWM_OFS_CKSEL, 32'h0);
		// Accumulate with pin B high: three ticks over two writes
		wr(`DCPWM_OFS_CNT2, 32'h20);
		wr(`DCPWM_OFS_CKSEL, 32'h18);
		wr(`DCPWM_OFS_CKSEL, 32'h0);
		rdc(`DCPWM_OFS_CNT2, 32'h1d);
		wr(`DCPWM_OFS_CTRL, 32'hd6);
		wr(`DCPWM_OFS_CKSEL, 32'h18);
		wr(`DCPWM_OFS_CKSEL, 32'h0);
		rdc(`DCPWM_OFS_CNT2, 32'h1d);
		wr(`DCPWM_OFS_IRQEN, 32'h0);
		wr(`DCPWM_OFS_PRSC, 32'h1f);
		rdc(`DCPWM_OFS_PRSC, 32'h1f);
		chk("irq one masked", 0, irq_timer_one);
		chk("irq two masked", 0, irq_timer_two);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`DCPWM_OFS_CTRL, 32'h0);
		apb(1'b0, 8'h24, 32'h0);
		chk("slave error", 1, e);
		t_pwm();
		t_dual_cap();
		t_single();
		t_timer();
		results();
	end
	initial begin
		#100000;
		mismatches++;
		results();
	end
endmodule
